// >>> hdl/pms_link_if.sv
// Command capture on the memory clock, handed to the core by a toggle handshake
module pms_link_if
(
  // Link clock and raw core reset
  input wire logic ck_link_i,
  input wire logic srst_i,
  // Commands from the controller
  input wire logic cmd_valid_i,
  input wire logic [pms_pkg::CODE_W-1:0] cmd_code_i,
  input wire logic [pms_pkg::CH_W-1:0] cmd_ch_i,
  input wire logic [pms_pkg::MA_W-1:0] cmd_ma_i,
  input wire logic [pms_pkg::OP_W-1:0] cmd_op_i,
  output logic cmd_ready_o,
  output logic rd_valid_o,
  output logic [pms_pkg::OP_W-1:0] rd_data_o,
  // Handshake with the core
  input wire logic ack_pulse_i,
  input wire logic [pms_pkg::OP_W-1:0] core_rd_data_i,
  output logic link_rst_o,
  output logic req_tgl_o,
  output logic [pms_pkg::CODE_W-1:0] code_o,
  output logic [pms_pkg::CH_W-1:0] ch_o,
  output logic [pms_pkg::MA_W-1:0] ma_o,
  output logic [pms_pkg::OP_W-1:0] op_o
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    pms_pkg::pms_link_st_e st;
    logic req_tgl;
    logic [pms_pkg::CODE_W-1:0] code;
    logic [pms_pkg::CH_W-1:0] ch;
    logic [pms_pkg::MA_W-1:0] ma;
    logic [pms_pkg::OP_W-1:0] op;
    logic ready;
    logic rd_valid;
    logic [pms_pkg::OP_W-1:0] rd_data;
  } pms_link_s;

  pms_link_s q;
  pms_link_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Fields stay frozen while busy, so the core may sample them on its pulse
  always_comb
  begin
    d = q;
    d.rst_s1 = srst_i;
    d.rst_s2 = q.rst_s1;
    d.rd_valid = 1'b0;
    if (q.rst_s2)
    begin
      d.st = pms_pkg::LNK_IDLE;
      d.req_tgl = 1'b0;
      d.code = pms_pkg::CMD_MRW;
      d.ch = '0;
      d.ma = '0;
      d.op = '0;
      d.ready = 1'b1;
      d.rd_data = pms_pkg::RD_ZERO;
    end
    else
    begin
      case (q.st)
        pms_pkg::LNK_IDLE:
        begin
          if (cmd_valid_i && q.ready)
          begin
            d.code = cmd_code_i;
            d.ch = cmd_ch_i;
            d.ma = cmd_ma_i;
            d.op = cmd_op_i;
            d.req_tgl = ~q.req_tgl;
            d.ready = 1'b0;
            d.st = pms_pkg::LNK_BUSY;
          end
        end
        pms_pkg::LNK_BUSY:
        begin
          // Core read data is held stable once its ack toggle is seen
          if (ack_pulse_i)
          begin
            d.ready = 1'b1;
            d.st = pms_pkg::LNK_IDLE;
            if (q.code == pms_pkg::CMD_MRR)
            begin
              d.rd_valid = 1'b1;
              d.rd_data = core_rd_data_i;
            end
          end
        end
        default:
        begin
          d.st = pms_pkg::LNK_IDLE;
          d.ready = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ck_link_i)
  begin
    q <= d;
  end

  assign cmd_ready_o = q.ready;
  assign rd_valid_o = q.rd_valid;
  assign rd_data_o = q.rd_data;
  assign link_rst_o = q.rst_s2;
  assign req_tgl_o = q.req_tgl;
  assign code_o = q.code;
  assign ch_o = q.ch;
  assign ma_o = q.ma;
  assign op_o = q.op;

endmodule : pms_link_if

// >>> hdl/pms_mode_regs.sv
// Self-refresh masks, calibration lane invert and strobe oscillator count mode registers
//
// Summary of operation
// - Invert bits 0-3 steer lanes 0-3, bits 4-7 lanes 4-7; mask lane never inverted.
// - Invert bit set flips that lane's calibration pattern; register resets to alternating value.
// - Bank mask sits at address sixteen, write-only, one bit per bank.
// - Bank mask bit n stops self refresh of bank n.
// - Bank mask bits reset to zero, all banks refreshed.
// - Each channel keeps its own bank mask.
// - Segment mask sits at address seventeen, write-only, eight bits.
// - Segment mask bit n stops self refresh of segment n; resets to zero.
// - Segment n is rows whose top three row address bits equal n.
// - Each channel keeps its own segment mask.
// - Address eighteen reads the low byte of the oscillator count.
// - Address nineteen reads the high byte of the oscillator count.
// - Oscillator start command clears both count registers of its channel unless a count finishes in the same cycle.
module pms_mode_regs
#(
  parameter int unsigned NUM_CH = pms_pkg::NUM_CH,
  parameter int unsigned ROW_W = pms_pkg::ROW_W_DEF
)
(
  // Core clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Memory clock for the command link
  input wire logic ck_link_i,
  // Mode register commands, on the memory clock
  input wire logic cmd_valid_i,
  input wire logic [pms_pkg::CODE_W-1:0] cmd_code_i,
  input wire logic [pms_pkg::CH_W-1:0] cmd_ch_i,
  input wire logic [pms_pkg::MA_W-1:0] cmd_ma_i,
  input wire logic [pms_pkg::OP_W-1:0] cmd_op_i,
  output logic cmd_ready_o,
  output logic rd_valid_o,
  output logic [pms_pkg::OP_W-1:0] rd_data_o,
  // Refresh masks toward the refresh engine
  output logic [NUM_CH-1:0][pms_pkg::NUM_BANKS-1:0] bank_mask_o,
  output logic [NUM_CH-1:0][pms_pkg::NUM_SEGS-1:0] seg_mask_o,
  // Self-refresh skip query
  input wire logic [pms_pkg::CH_W-1:0] sr_ch_i,
  input wire logic [pms_pkg::BANK_W-1:0] sr_bank_i,
  input wire logic [ROW_W-1:0] sr_row_i,
  output logic sr_skip_o,
  // Strobe oscillator
  output logic [NUM_CH-1:0] osc_start_o,
  input wire logic [NUM_CH-1:0] osc_done_i,
  input wire logic [NUM_CH-1:0][pms_pkg::OSC_W-1:0] osc_count_i,
  output logic [NUM_CH-1:0][pms_pkg::OSC_W-1:0] osc_count_o,
  // Calibration pattern lanes
  input wire logic [pms_pkg::CH_W-1:0] cal_ch_i,
  input wire logic [pms_pkg::OP_W-1:0] cal_dq_i,
  input wire logic cal_mask_lane_i,
  output logic [pms_pkg::OP_W-1:0] cal_dq_o,
  output logic cal_mask_lane_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Core state

  typedef struct packed {
    logic [NUM_CH-1:0][pms_pkg::OP_W-1:0] inv;
    logic [NUM_CH-1:0][pms_pkg::NUM_BANKS-1:0] bank;
    logic [NUM_CH-1:0][pms_pkg::NUM_SEGS-1:0] seg;
    logic [NUM_CH-1:0][pms_pkg::OSC_W-1:0] cnt;
    logic [NUM_CH-1:0] osc_start;
    logic ack_tgl;
    logic [pms_pkg::OP_W-1:0] rd_data;
    logic sr_skip;
    logic [pms_pkg::OP_W-1:0] cal_dq;
    logic cal_mask;
  } pms_core_s;

  pms_core_s q;
  pms_core_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Link side and crossings

  logic link_rst;
  logic req_tgl;
  logic req_pulse;
  logic ack_pulse;
  logic [pms_pkg::CODE_W-1:0] lnk_code;
  logic [pms_pkg::CH_W-1:0] lnk_ch;
  logic [pms_pkg::MA_W-1:0] lnk_ma;
  logic [pms_pkg::OP_W-1:0] lnk_op;

  // Command capture runs on the memory clock
  pms_link_if u_link
  (
    .ck_link_i(ck_link_i),
    .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i),
    .cmd_ch_i(cmd_ch_i),
    .cmd_ma_i(cmd_ma_i),
    .cmd_op_i(cmd_op_i),
    .cmd_ready_o(cmd_ready_o),
    .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o),
    .ack_pulse_i(ack_pulse),
    .core_rd_data_i(q.rd_data),
    .link_rst_o(link_rst),
    .req_tgl_o(req_tgl),
    .code_o(lnk_code),
    .ch_o(lnk_ch),
    .ma_o(lnk_ma),
    .op_o(lnk_op)
  );

  // Request toggle into the core domain
  pms_tgl_sync u_req_sync
  (
    .clk_i(sys_clk_i),
    .rst_i(srst_i),
    .tgl_i(req_tgl),
    .pulse_o(req_pulse)
  );

  // Acknowledge toggle back to the memory clock
  pms_tgl_sync u_ack_sync
  (
    .clk_i(ck_link_i),
    .rst_i(link_rst),
    .tgl_i(q.ack_tgl),
    .pulse_o(ack_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Link fields are frozen from request toggle until acknowledge, so they are
  // safe to read on req_pulse without their own synchronisers.

  always_comb
  begin
    d = q;
    d.osc_start = '0;

    // Calibration lanes: data lanes follow invert bits, mask lane passes true
    d.cal_dq = cal_dq_i ^ q.inv[cal_ch_i];
    d.cal_mask = cal_mask_lane_i;

    // Skip refresh if either the bank or the row's segment is masked
    d.sr_skip = q.bank[sr_ch_i][sr_bank_i]
      | q.seg[sr_ch_i][sr_row_i[ROW_W-1 -: pms_pkg::SEG_BITS]];

    // Commands handed over from the link
    if (req_pulse)
    begin
      d.ack_tgl = ~q.ack_tgl;
      d.rd_data = pms_pkg::RD_ZERO;
      if (lnk_code == pms_pkg::CMD_MRW)
      begin
        // Writes to read-only or unmapped addresses are dropped
        if (lnk_ma == pms_pkg::MA_LANE_INV)
        begin
          d.inv[lnk_ch] = lnk_op;
        end
        else if (lnk_ma == pms_pkg::MA_BANK_MASK)
        begin
          d.bank[lnk_ch] = lnk_op;
        end
        else if (lnk_ma == pms_pkg::MA_SEG_MASK)
        begin
          d.seg[lnk_ch] = lnk_op;
        end
      end
      else if (lnk_code == pms_pkg::CMD_MRR)
      begin
        // Write-only registers read back as zero
        if (lnk_ma == pms_pkg::MA_OSC_LOW)
        begin
          d.rd_data = q.cnt[lnk_ch][pms_pkg::OSC_LOW_LSB +: pms_pkg::OP_W];
        end
        else if (lnk_ma == pms_pkg::MA_OSC_HIGH)
        begin
          d.rd_data = q.cnt[lnk_ch][pms_pkg::OSC_HIGH_LSB +: pms_pkg::OP_W];
        end
      end
      else if (lnk_code == pms_pkg::CMD_OSC_START)
      begin
        d.cnt[lnk_ch] = pms_pkg::RST_OSC_COUNT;
        d.osc_start[lnk_ch] = 1'b1;
      end
    end

    // A finished count lands after the clear, so a result is never lost
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (osc_done_i[i])
      begin
        d.cnt[i] = osc_count_i[i];
      end
    end

    // Synchronous reset
    if (srst_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        d.inv[i] = pms_pkg::RST_LANE_INV;
        d.bank[i] = pms_pkg::RST_BANK_MASK;
        d.seg[i] = pms_pkg::RST_SEG_MASK;
        d.cnt[i] = pms_pkg::RST_OSC_COUNT;
      end
      d.osc_start = '0;
      d.ack_tgl = 1'b0;
      d.rd_data = pms_pkg::RD_ZERO;
      d.sr_skip = 1'b0;
      d.cal_dq = '0;
      d.cal_mask = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk_i)
  begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign bank_mask_o = q.bank;
  assign seg_mask_o = q.seg;
  assign sr_skip_o = q.sr_skip;
  assign osc_start_o = q.osc_start;
  assign osc_count_o = q.cnt;
  assign cal_dq_o = q.cal_dq;
  assign cal_mask_lane_o = q.cal_mask;

endmodule : pms_mode_regs

// >>> hdl/pms_tgl_sync.sv
// Toggle-to-pulse synchroniser for events crossing between clock domains
module pms_tgl_sync
(
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Toggle from the other domain, pulse in this one
  input wire logic tgl_i,
  output logic pulse_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } pms_sync_s;

  pms_sync_s q;
  pms_sync_s d;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; edge found between stages two and three
  always_comb
  begin
    d = q;
    d.s1 = tgl_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pulse = q.s2 ^ q.s3;
    if (rst_i)
    begin
      d = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign pulse_o = q.pulse;

endmodule : pms_tgl_sync

// >>> pkg/pms_pkg.sv
// Shared constants and types for the self-refresh mask and oscillator count mode registers
package pms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CH_W = 1;
  localparam int unsigned MA_W = 6;
  localparam int unsigned OP_W = 8;
  localparam int unsigned CODE_W = 2;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned NUM_SEGS = 8;
  localparam int unsigned SEG_BITS = 3;
  localparam int unsigned OSC_W = 16;
  localparam int unsigned ROW_W_DEF = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register addresses
  localparam logic [MA_W-1:0] MA_LANE_INV = 6'h0f;
  localparam logic [MA_W-1:0] MA_BANK_MASK = 6'h10;
  localparam logic [MA_W-1:0] MA_SEG_MASK = 6'h11;
  localparam logic [MA_W-1:0] MA_OSC_LOW = 6'h12;
  localparam logic [MA_W-1:0] MA_OSC_HIGH = 6'h13;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions
  localparam logic [OP_W-1:0] RST_LANE_INV = 8'h55;
  localparam logic [OP_W-1:0] RST_BANK_MASK = 8'h00;
  localparam logic [OP_W-1:0] RST_SEG_MASK = 8'h00;
  localparam logic [OSC_W-1:0] RST_OSC_COUNT = 16'h0000;
  localparam logic [OP_W-1:0] RD_ZERO = 8'h00;
  localparam int unsigned OSC_LOW_LSB = 0;
  localparam int unsigned OSC_HIGH_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Link commands and link-side states
  typedef enum logic [CODE_W-1:0] {
    CMD_MRW = 2'h0,
    CMD_MRR = 2'h1,
    CMD_OSC_START = 2'h2
  } pms_cmd_e;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'b01,
    LNK_BUSY = 2'b10
  } pms_link_st_e;

endpackage : pms_pkg

// >>> verification/pms_ctrl_model.sv
// Memory controller model issuing mode register commands on the link clock
module pms_ctrl_model
(
  // Link clock and device answers
  input wire logic ck_link_i,
  input wire logic cmd_ready_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  // Command fields
  output logic cmd_valid_o,
  output logic [1:0] cmd_code_o,
  output logic cmd_ch_o,
  output logic [5:0] cmd_ma_o,
  output logic [7:0] cmd_op_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid_o = 1'b0;
    {cmd_code_o, cmd_ch_o, cmd_ma_o, cmd_op_o} = '0;
  end

  // One command, held until taken; released fields flip so stale values never look valid
  task automatic issue(input logic [1:0] code, input logic ch, input logic [5:0] ma, input logic [7:0] op,
    input int gap, output logic [7:0] rd);
    // A device that never answers is caught by the bench watchdog
    repeat (gap) @(posedge ck_link_i);
    do
    begin
      @(posedge ck_link_i);
    end
    while (cmd_ready_i !== 1'b1);
    cmd_valid_o <= 1'b1;
    {cmd_code_o, cmd_ch_o, cmd_ma_o, cmd_op_o} <= {code, ch, ma, op};
    @(posedge ck_link_i);
    cmd_valid_o <= 1'b0;
    {cmd_code_o, cmd_ch_o, cmd_ma_o, cmd_op_o} <= ~{code, ch, ma, op};
    do
    begin
      @(posedge ck_link_i);
    end
    while (cmd_ready_i !== 1'b1);
    // Read data only counts with its valid pulse
    rd = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
  endtask : issue
endmodule : pms_ctrl_model

// >>> verification/pms_mode_regs_asserts.sv
// Port-level checks on the mode register block
module pms_mode_regs_asserts
#(
  parameter int unsigned NUM_CH = 2,
  parameter int unsigned ROW_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Masks and skip query
  input wire logic [NUM_CH-1:0][pms_pkg::NUM_BANKS-1:0] bank_mask_o,
  input wire logic [NUM_CH-1:0][pms_pkg::NUM_SEGS-1:0] seg_mask_o,
  input wire logic [pms_pkg::CH_W-1:0] sr_ch_i,
  input wire logic [pms_pkg::BANK_W-1:0] sr_bank_i,
  input wire logic [ROW_W-1:0] sr_row_i,
  input wire logic sr_skip_o,
  // Oscillator
  input wire logic [NUM_CH-1:0] osc_start_o,
  input wire logic [NUM_CH-1:0] osc_done_i,
  input wire logic [NUM_CH-1:0][pms_pkg::OSC_W-1:0] osc_count_i,
  input wire logic [NUM_CH-1:0][pms_pkg::OSC_W-1:0] osc_count_o,
  // Calibration lanes
  input wire logic [pms_pkg::OP_W-1:0] cal_dq_i,
  input wire logic [pms_pkg::OP_W-1:0] cal_dq_o,
  input wire logic cal_mask_lane_i,
  input wire logic cal_mask_lane_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Lane inversion; the first cycle after reset still shows reset outputs
  AST_CAL_LANE: assert property (!$past(srst_i) |-> cal_mask_lane_o == $past(cal_mask_lane_i))
    else $error("mask lane not passed through");
  AST_CAL_RST_INV: assert property ($fell(srst_i) |=> cal_dq_o == ($past(cal_dq_i) ^ 8'h55))
    else $error("default inversion wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Refresh masks
  AST_BANK_RST: assert property ($past(srst_i) |-> bank_mask_o == '0)
    else $error("bank mask reset wrong");
  AST_SEG_RST: assert property ($past(srst_i) |-> seg_mask_o == '0)
    else $error("segment mask reset wrong");
  AST_SKIP: assert property (!$past(srst_i) |-> sr_skip_o ==
    $past(bank_mask_o[sr_ch_i][sr_bank_i] | seg_mask_o[sr_ch_i][sr_row_i[ROW_W-1 -: 3]]))
    else $error("skip answer wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator count
  AST_OSC_PULSE: assert property (osc_start_o[0] |=> !osc_start_o[0])
    else $error("start not a single pulse");
  AST_OSC_CLR: assert property (osc_start_o[0] && !osc_done_i[0] |-> ##[0:1] osc_count_o[0] == 16'h0000)
    else $error("count not cleared by start");
  AST_OSC_LOAD: assert property (osc_done_i[1] |=> osc_count_o[1] == $past(osc_count_i[1]))
    else $error("count not loaded");
endmodule : pms_mode_regs_asserts

bind pms_mode_regs pms_mode_regs_asserts #(.NUM_CH(NUM_CH), .ROW_W(ROW_W)) i_asserts (.sys_clk_i, .srst_i,
  .bank_mask_o, .seg_mask_o, .sr_ch_i, .sr_bank_i, .sr_row_i, .sr_skip_o, .osc_start_o, .osc_done_i,
  .osc_count_i, .osc_count_o, .cal_dq_i, .cal_dq_o, .cal_mask_lane_i, .cal_mask_lane_o);

// >>> verification/test_pms_mode_regs.sv
// Directed bench for the mode register block with a controller model on the link
module test_pms_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i;
  logic srst_i;
  logic ck_link_i;
  logic cmd_valid_i;
  logic [1:0] cmd_code_i;
  logic [0:0] cmd_ch_i;
  logic [5:0] cmd_ma_i;
  logic [7:0] cmd_op_i;
  logic cmd_ready_o;
  logic rd_valid_o;
  logic [7:0] rd_data_o;
  logic [1:0][7:0] bank_mask_o;
  logic [1:0][7:0] seg_mask_o;
  logic [0:0] sr_ch_i;
  logic [2:0] sr_bank_i;
  logic [15:0] sr_row_i;
  logic sr_skip_o;
  logic [1:0] osc_start_o;
  logic [1:0] osc_done_i;
  logic [1:0][15:0] osc_count_i;
  logic [1:0][15:0] osc_count_o;
  logic [0:0] cal_ch_i;
  logic [7:0] cal_dq_i;
  logic cal_mask_lane_i;
  logic [7:0] cal_dq_o;
  logic cal_mask_lane_o;
  logic [7:0] rd;
  logic [1:0][7:0] bm;
  logic [1:0][7:0] sm;
  logic [15:0] joined;
  int start_seen = 0;
  int num_errors;
  int check_count;

  ////////////////////////////////////////////////////////////////////////////
  // Clocks, the link one offset so the phases never line up
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    ck_link_i = 1'b0;
    #7;
    forever #40 ck_link_i = ~ck_link_i;
  end

  pms_mode_regs i_dut (.sys_clk_i, .srst_i, .ck_link_i, .cmd_valid_i, .cmd_code_i, .cmd_ch_i, .cmd_ma_i,
    .cmd_op_i, .cmd_ready_o, .rd_valid_o, .rd_data_o, .bank_mask_o, .seg_mask_o, .sr_ch_i, .sr_bank_i,
    .sr_row_i, .sr_skip_o, .osc_start_o, .osc_done_i, .osc_count_i, .osc_count_o, .cal_ch_i, .cal_dq_i,
    .cal_mask_lane_i, .cal_dq_o, .cal_mask_lane_o);
  pms_ctrl_model i_ctrl (.ck_link_i, .cmd_ready_i(cmd_ready_o), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_ch_o(cmd_ch_i), .cmd_ma_o(cmd_ma_i),
    .cmd_op_o(cmd_op_i));

  // Start pulses on channel 0; a stretched pulse would count twice
  always @(posedge sys_clk_i)
  begin
    if (osc_start_o[0] === 1'b1)
    begin
      start_seen <= start_seen + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus access and closing tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic mrr(input logic ch, input logic [5:0] ma, input logic [7:0] exp);
    i_ctrl.issue(2'h1, ch, ma, 8'h00, 2, rd);
    chk({8'h00, rd}, {8'h00, exp});
  endtask : mrr
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : settle
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Watchdog well beyond the 18 commands of the run
  initial
  begin
    #100us;
    num_errors++;
    test_done();
  end

  initial
  begin
    num_errors = 0;
    check_count = 0;
    srst_i = 1'b1;
    {sr_ch_i, sr_bank_i, sr_row_i, osc_done_i, osc_count_i} = '0;
    {cal_ch_i, cal_dq_i, cal_mask_lane_i} = '0;
    // Reset spans three link edges so the link side sees it
    repeat (3) @(posedge ck_link_i);
    @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Link reset trails by two synchroniser stages; earlier commands are dropped
    repeat (3) @(posedge ck_link_i);
    @(posedge sys_clk_i);
    cal_dq_i <= 8'hff;
    cal_mask_lane_i <= 1'b1;
    settle(2);
    chk(cal_dq_o, 16'h00aa);
    chk(cal_mask_lane_o, 16'h0001);
    chk(bank_mask_o, 16'h0000);
    chk(seg_mask_o, 16'h0000);
    $display("reset test done");
    // Top segment bit used only because this density has all eight segments
    bm = 16'h5aa5;
    sm = 16'h3c81;
    for (int c = 0; c < 2; c++)
    begin
      i_ctrl.issue(2'h0, c[0], pms_pkg::MA_BANK_MASK, bm[c], 0, rd);
      i_ctrl.issue(2'h0, c[0], pms_pkg::MA_SEG_MASK, sm[c], 1, rd);
    end
    chk(bank_mask_o, bm);
    chk(seg_mask_o, sm);
    mrr(1'b0, pms_pkg::MA_BANK_MASK, 8'h00);
    mrr(1'b1, pms_pkg::MA_SEG_MASK, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sys_clk_i);
      sr_ch_i <= i[3];
      sr_bank_i <= i[2:0];
      sr_row_i <= {~i[2:0], 13'h0155};
      settle(1);
      chk(sr_skip_o, bm[i[3]][i[2:0]] | sm[i[3]][~i[2:0]]);
    end
    $display("mask test done");
    i_ctrl.issue(2'h0, 1'b1, pms_pkg::MA_LANE_INV, 8'h0f, 0, rd);
    @(posedge sys_clk_i);
    cal_ch_i <= 1'b1;
    cal_dq_i <= 8'h33;
    cal_mask_lane_i <= 1'b0;
    settle(2);
    chk(cal_dq_o, 16'h003c);
    chk(cal_mask_lane_o, 16'h0000);
    @(posedge sys_clk_i);
    cal_ch_i <= 1'b0;
    settle(2);
    chk(cal_dq_o, 16'h0066);
    $display("invert test done");
    @(posedge sys_clk_i);
    osc_count_i <= 32'hbeef1234;
    osc_done_i <= 2'b11;
    @(posedge sys_clk_i);
    osc_done_i <= 2'b00;
    i_ctrl.issue(2'h0, 1'b0, pms_pkg::MA_OSC_LOW, 8'hff, 0, rd);
    mrr(1'b0, pms_pkg::MA_OSC_LOW, 8'h34);
    mrr(1'b0, pms_pkg::MA_OSC_HIGH, 8'h12);
    mrr(1'b1, pms_pkg::MA_OSC_LOW, 8'hef);
    joined[7:0] = rd;
    mrr(1'b1, pms_pkg::MA_OSC_HIGH, 8'hbe);
    joined[15:8] = rd;
    chk(joined, 16'hbeef);
    chk(osc_count_o[0], 16'h1234);
    chk(osc_count_o[1], 16'hbeef);
    i_ctrl.issue(pms_pkg::CMD_OSC_START, 1'b0, 6'h00, 8'h00, 0, rd);
    mrr(1'b0, pms_pkg::MA_OSC_LOW, 8'h00);
    mrr(1'b0, pms_pkg::MA_OSC_HIGH, 8'h00);
    mrr(1'b1, pms_pkg::MA_OSC_HIGH, 8'hbe);
    chk(start_seen[15:0], 16'h0001);
    i_ctrl.issue(2'h3, 1'b0, 6'h00, 8'h00, 0, rd);
    mrr(1'b1, 6'h3f, 8'h00);
    $display("oscillator test done");
    test_done();
  end
endmodule : test_pms_mode_regs
